// *** src/bsl_map.svh ***
// offsets, field positions, reset values and fixed addresses of the loader
`ifndef BSL_MAP_SVH
`define BSL_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BSL_OFF_SYSRST 8'h00
`define BSL_OFF_CTRL 8'h04
`define BSL_OFF_STATUS 8'h08
`define BSL_OFF_GHDR 8'h0c
`define BSL_OFF_COREA 8'h10
`define BSL_OFF_PTR 8'h14

// ****************************************
// field positions
// ****************************************
`define BSL_SOFT_RESET_BIT 4
`define BSL_CORE_B_IDLE_BIT 5
`define BSL_CTRL_RESTART_BIT 0
`define BSL_FLAG_ZEROFILL 0
`define BSL_FLAG_INIT 3
`define BSL_FLAG_IGNORE 4
`define BSL_FLAG_FINAL 15

// ****************************************
// reset values and constants
// ****************************************
`define BSL_SYSRST_RESET 32'h0000_0000
`define BSL_COREA_RESET 32'h0000_0020
`define BSL_DEF_WAIT 4'hf
`define BSL_DEF_HOLD 2'h3
`define BSL_DEF_BAUD 3'h0
`define BSL_SIG_VALID 4'ha
`define BSL_LOWEST_LEVEL 4'hf
`define BSL_CORE_A_START 32'hffa0_0000
`define BSL_CORE_B_START 32'hff60_0000
`define BSL_GHDR_BYTES 4'h4
`define BSL_BHDR_BYTES 4'ha

`endif

// *** src/bsl_pkg.sv ***
// types shared by the boot stream loader files
package bsl_pkg;

   typedef enum logic [3:0] {
      BSL_ENTRY = 4'h0,
      BSL_GHDR = 4'h1,
      BSL_GCHK = 4'h2,
      BSL_BHDR = 4'h3,
      BSL_DECIDE = 4'h4,
      BSL_COPY = 4'h5,
      BSL_FILL = 4'h6,
      BSL_SKIP = 4'h7,
      BSL_NEXT = 4'h8,
      BSL_INIT = 4'h9,
      BSL_JUMP = 4'ha,
      BSL_DONE = 4'hb,
      BSL_HALT = 4'hc
   } bsl_state_type;

   // global header, bit 0 at the bottom
   typedef struct packed {
      logic [3:0] sig;
      logic [16:0] rsvd;
      logic [2:0] baud;
      logic [1:0] hold;
      logic unused;
      logic [3:0] wait_st;
      logic width16;
   } bsl_ghdr_type;

   // block header as it sits after ten bytes, lsb first
   typedef struct packed {
      logic [15:0] flags;
      logic [31:0] count;
      logic [31:0] addr;
   } bsl_bhdr_type;

endpackage

// *** src/bsl_collect.sv ***
// little-endian header byte collector
module bsl_collect
   import bsl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic shift_i,
   input wire logic [7:0] byte_i,
   output bsl_bhdr_type hdr_o
);

   logic [79:0] sr;

   // new bytes enter at the top so the first byte ends up lowest
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sr <= 80'h0;
      end else if (shift_i) begin
         sr <= {byte_i, sr[79:8]};
      end
   end

   assign hdr_o = sr;

endmodule

// *** src/bsl_loader.sv ***
// boot stream loader: header parsing, block copy, core start, ahb registers
// Operation
// - after loading, jump core A to its level-one instruction start
// - at entry test soft-reset bit 4; clear means full boot
// - soft-reset bit set skips parsing and jumps straight to core A start
// - on entry move to lowest user interrupt level, stay supervisor
// - released core B starts at its fixed start address
// - a four-byte global header is read first
// - global header bit 0 picks 16-bit flash, default 8-bit
// - global header bits 1-4 give wait states, default fifteen
// - global header bits 6-7 give hold cycles, default three
// - global header bits 8-10 pick spi baud rate
// - bit 5 and bits 11-27 carry no meaning
// - bad upper-four-bit signature refuses the stream
// - block header is address, count, then flag word
// - flags mark zero-fill or final block, processed accordingly
// - ignore flag skips payload, address unused, no memory writes
// - multi-byte fields arrive least significant byte first
// - ordinary blocks copy count bytes to the destination address
// - init block loads, runs at once, parsing resumes on return
//
// The register offsets and the AHB-Lite register port were left to the implementer.
module bsl_loader
   import bsl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   output logic stream_req_o,
   output logic [31:0] stream_addr_o,
   input wire logic stream_valid_i,
   input wire logic [7:0] stream_data_i,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic flash_16bit_o,
   output logic [3:0] wait_states_o,
   output logic [1:0] hold_cycles_o,
   output logic [2:0] spi_baud_o,
   output logic [3:0] int_level_o,
   output logic supervisor_o,
   output logic init_call_o,
   output logic [31:0] init_addr_o,
   input wire logic init_done_i,
   output logic core_a_jump_o,
   output logic [31:0] core_a_pc_o,
   output logic core_b_run_o,
   output logic [31:0] core_b_pc_o,
   output logic sig_error_o
);
`include "bsl_map.svh"

   bsl_state_type state;
   bsl_bhdr_type hdr;
   bsl_ghdr_type ghdr;
   logic [31:0] system_reset_config_register;
   logic [31:0] core_a_cfg;
   logic [31:0] remain;
   logic [31:0] dest;
   logic [15:0] flags;
   logic [3:0] hdr_cnt;
   logic restart;
   logic take;
   logic reading;
   logic d_wr;
   logic [7:0] d_addr;
   logic a_ok;

   // ****************************************
   // stream byte handshake
   // ****************************************
   assign reading = (state == BSL_GHDR) || (state == BSL_BHDR) ||
                    (state == BSL_COPY) || (state == BSL_SKIP);
   assign take = stream_req_o && stream_valid_i;

   // one byte per request; request drops on the edge its byte is taken
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stream_req_o <= 1'b0;
      end else if (take) begin
         stream_req_o <= 1'b0;
      end else begin
         stream_req_o <= reading;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i || (state == BSL_ENTRY)) begin
         stream_addr_o <= 32'h0;
      end else if (take) begin
         stream_addr_o <= stream_addr_o + 32'h1;
      end
   end

   bsl_collect u_collect (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .shift_i(take && ((state == BSL_GHDR) || (state == BSL_BHDR))),
      .byte_i(stream_data_i),
      .hdr_o(hdr)
   );
   // global header is the top four bytes after four shifts
   assign ghdr = hdr[79:48];

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= BSL_ENTRY;
         hdr_cnt <= 4'h0;
         remain <= 32'h0;
         dest <= 32'h0;
         flags <= 16'h0;
      end else begin
         case (state)
            BSL_ENTRY: begin
               hdr_cnt <= 4'h0;
               if (system_reset_config_register[`BSL_SOFT_RESET_BIT])
                  state <= BSL_JUMP;
               else
                  state <= BSL_GHDR;
            end
            BSL_GHDR: begin
               if (take) begin
                  hdr_cnt <= hdr_cnt + 4'h1;
                  if (hdr_cnt == `BSL_GHDR_BYTES - 4'h1) begin
                     state <= BSL_GCHK;
                  end
               end
            end
            BSL_GCHK: begin
               hdr_cnt <= 4'h0;
               if (ghdr.sig == `BSL_SIG_VALID)
                  state <= BSL_BHDR;
               else
                  state <= BSL_HALT;
            end
            BSL_BHDR: begin
               // count block parsed like any other header
               if (take) begin
                  hdr_cnt <= hdr_cnt + 4'h1;
                  if (hdr_cnt == `BSL_BHDR_BYTES - 4'h1) begin
                     state <= BSL_DECIDE;
                  end
               end
            end
            BSL_DECIDE: begin
               hdr_cnt <= 4'h0;
               dest <= hdr.addr;
               remain <= hdr.count;
               flags <= hdr.flags;
               // ignore wins over zero-fill and init; a final flag still ends the stream
               if (hdr.flags[`BSL_FLAG_IGNORE])
                  state <= (hdr.count == 32'h0) ? BSL_NEXT : BSL_SKIP;
               else if (hdr.count == 32'h0)
                  state <= BSL_NEXT;
               else if (hdr.flags[`BSL_FLAG_ZEROFILL])
                  state <= BSL_FILL;
               else
                  state <= BSL_COPY;
            end
            BSL_COPY, BSL_SKIP: begin
               if (take) begin
                  remain <= remain - 32'h1;
                  dest <= dest + 32'h1;
                  if (remain == 32'h1) begin
                     state <= BSL_NEXT;
                  end
               end
            end
            BSL_FILL: begin
               remain <= remain - 32'h1;
               dest <= dest + 32'h1;
               if (remain == 32'h1) begin
                  state <= BSL_NEXT;
               end
            end
            BSL_NEXT: begin
               // init block runs before parsing resumes
               if (flags[`BSL_FLAG_INIT] && !flags[`BSL_FLAG_IGNORE])
                  state <= BSL_INIT;
               else if (flags[`BSL_FLAG_FINAL])
                  state <= BSL_JUMP;
               else
                  state <= BSL_BHDR;
            end
            BSL_INIT: begin
               if (init_done_i && !init_call_o) begin
                  state <= flags[`BSL_FLAG_FINAL] ? BSL_JUMP : BSL_BHDR;
               end
            end
            BSL_JUMP: begin
               state <= BSL_DONE;
            end
            BSL_DONE, BSL_HALT: begin
               if (restart) begin
                  state <= BSL_ENTRY;
               end
            end
            default: begin
               state <= BSL_HALT;
            end
         endcase
      end
   end

   // ****************************************
   // memory writes
   // ****************************************
   // copy payload
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h0;
         mem_wdata_o <= 8'h0;
      end else begin
         mem_we_o <= ((state == BSL_COPY) && take) || (state == BSL_FILL);
         mem_addr_o <= dest;
         mem_wdata_o <= (state == BSL_COPY) ? stream_data_i : 8'h0;
      end
   end

   // ****************************************
   // flash configuration from global header
   // ****************************************
   // slowest settings until a good header is seen
   // unused and reserved bits are not decoded
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flash_16bit_o <= 1'b0;
         wait_states_o <= `BSL_DEF_WAIT;
         hold_cycles_o <= `BSL_DEF_HOLD;
         spi_baud_o <= `BSL_DEF_BAUD;
      end else if ((state == BSL_GCHK) && (ghdr.sig == `BSL_SIG_VALID)) begin
         flash_16bit_o <= ghdr.width16;
         wait_states_o <= ghdr.wait_st;
         hold_cycles_o <= ghdr.hold;
         spi_baud_o <= ghdr.baud;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sig_error_o <= 1'b0;
      end else if (state == BSL_ENTRY) begin
         sig_error_o <= 1'b0;
      end else if ((state == BSL_GCHK) && (ghdr.sig != `BSL_SIG_VALID)) begin
         sig_error_o <= 1'b1;
      end
   end

   // ****************************************
   // execution handoff
   // ****************************************
   // lowest user level, supervisor kept
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         int_level_o <= 4'h0;
         supervisor_o <= 1'b1;
      end else if (state == BSL_ENTRY) begin
         int_level_o <= `BSL_LOWEST_LEVEL;
         supervisor_o <= 1'b1;
      end
   end

   // init routine called once, at its own load address
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         init_call_o <= 1'b0;
         init_addr_o <= 32'h0;
      end else begin
         init_call_o <= (state == BSL_NEXT) && flags[`BSL_FLAG_INIT] &&
                        !flags[`BSL_FLAG_IGNORE];
         if (state == BSL_DECIDE) begin
            init_addr_o <= hdr.addr;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_a_jump_o <= 1'b0;
         core_a_pc_o <= 32'h0;
      end else begin
         core_a_jump_o <= (state == BSL_JUMP);
         if (state == BSL_JUMP) begin
            core_a_pc_o <= `BSL_CORE_A_START;
         end
      end
   end

   // core B waits for bit 5 clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_b_run_o <= 1'b0;
         core_b_pc_o <= 32'h0;
      end else if ((state == BSL_DONE) &&
                   !core_a_cfg[`BSL_CORE_B_IDLE_BIT]) begin
         core_b_run_o <= 1'b1;
         core_b_pc_o <= `BSL_CORE_B_START;
      end
   end

   // ****************************************
   // ahb-lite register slave
   // ****************************************
   // zero wait states; only word transfers are expected
   assign a_ok = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         d_wr <= 1'b0;
         d_addr <= 8'h0;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         d_wr <= a_ok && hwrite_i && (hsize_i == 3'h2);
         d_addr <= haddr_i[7:0];
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         system_reset_config_register <= `BSL_SYSRST_RESET;
         core_a_cfg <= `BSL_COREA_RESET;
         restart <= 1'b0;
      end else begin
         restart <= d_wr && (d_addr == `BSL_OFF_CTRL) &&
                    hwdata_i[`BSL_CTRL_RESTART_BIT];
         if (d_wr && (d_addr == `BSL_OFF_SYSRST)) begin
            system_reset_config_register <= hwdata_i;
         end
         if (d_wr && (d_addr == `BSL_OFF_COREA)) begin
            core_a_cfg <= hwdata_i;
         end
      end
   end

   // read data registered in the address phase, stands in the data phase
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hrdata_o <= 32'h0;
      end else if (a_ok && !hwrite_i) begin
         case (haddr_i[7:0])
            `BSL_OFF_SYSRST: hrdata_o <= system_reset_config_register;
            `BSL_OFF_STATUS: hrdata_o <= {21'h0, core_b_run_o,
                                          (state == BSL_DONE), sig_error_o,
                                          4'h0, state};
            `BSL_OFF_GHDR: hrdata_o <= ghdr;
            `BSL_OFF_COREA: hrdata_o <= core_a_cfg;
            `BSL_OFF_PTR: hrdata_o <= stream_addr_o;
            default: hrdata_o <= 32'h0;
         endcase
      end else begin
         hrdata_o <= 32'h0;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_jump_pc;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_JUMP) |=> core_a_jump_o &&
         (core_a_pc_o == `BSL_CORE_A_START) && (state == BSL_DONE);
   endproperty
   a_jump_pc: assert property (p_jump_pc)
      else $error("core A jump missing or wrong address");

   property p_hard_boot;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_ENTRY) && !system_reset_config_register[4] |=>
         (state == BSL_GHDR) && (int_level_o == 4'hf);
   endproperty
   a_hard_boot: assert property (p_hard_boot)
      else $error("hard reset did not start header read");

   property p_soft_skip;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_ENTRY) && system_reset_config_register[4] |=>
         (state == BSL_JUMP) ##1 core_a_jump_o && !mem_we_o;
   endproperty
   a_soft_skip: assert property (p_soft_skip)
      else $error("soft reset did not bypass boot");

   property p_core_b;
      @(posedge clk_i) disable iff (reset_i)
      $rose(core_b_run_o) |-> (core_b_pc_o == `BSL_CORE_B_START) &&
         !core_a_cfg[5] && $past(state == BSL_DONE);
   endproperty
   a_core_b: assert property (p_core_b)
      else $error("core B started wrongly");

   property p_ghdr_len;
      @(posedge clk_i) disable iff (reset_i)
      $rose(state == BSL_GCHK) |-> (stream_addr_o == 32'h4);
   endproperty
   a_ghdr_len: assert property (p_ghdr_len)
      else $error("global header not four bytes");

   property p_cfg_load;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_GCHK) && (ghdr.sig == 4'ha) |=>
         (flash_16bit_o == $past(ghdr.width16)) &&
         (wait_states_o == $past(ghdr.wait_st)) &&
         (hold_cycles_o == $past(ghdr.hold)) &&
         (spi_baud_o == $past(ghdr.baud));
   endproperty
   a_cfg_load: assert property (p_cfg_load)
      else $error("flash settings not taken from header");

   property p_sig_stop;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_GCHK) && (ghdr.sig != 4'ha) |=>
         (sig_error_o && (state == BSL_HALT)) [*4];
   endproperty
   a_sig_stop: assert property (p_sig_stop)
      else $error("bad signature did not halt");

   property p_ignore;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_SKIP) |=> !mem_we_o;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("ignored block wrote memory");

   property p_copy;
      @(posedge clk_i) disable iff (reset_i)
      (state == BSL_COPY) && take |=> mem_we_o &&
         (mem_wdata_o == $past(stream_data_i)) &&
         (mem_addr_o == $past(dest));
   endproperty
   a_copy: assert property (p_copy)
      else $error("payload byte not written to destination");

   property p_init;
      @(posedge clk_i) disable iff (reset_i)
      $rose(init_call_o) |-> (state == BSL_INIT) && !core_a_jump_o;
   endproperty
   a_init: assert property (p_init)
      else $error("init call out of sequence");

endmodule

// *** tb/bsl_flash_model.sv ***
// byte-wide boot stream source standing in for the external flash
module bsl_flash_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic [3:0] delay_i,
   output logic valid_o,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // stream image and answer timing
   // ****************************************
   logic [7:0] mem [64];
   logic [3:0] wait_cnt;

   // the data bus keeps toggling while no byte is offered, so a loader
   // that samples without valid reads garbage rather than a stale byte
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         valid_o <= 1'b0;
         data_o <= 8'h00;
         wait_cnt <= 4'h0;
      end else if (valid_o) begin
         valid_o <= 1'b0;
         data_o <= ~data_o;
      end else if (req_i && wait_cnt >= delay_i) begin
         valid_o <= 1'b1;
         data_o <= mem[addr_i[5:0]];
         wait_cnt <= 4'h0;
      end else begin
         wait_cnt <= req_i ? wait_cnt + 4'h1 : 4'h0;
         data_o <= ~data_o;
      end
   end
endmodule

// *** tb/bsl_loader_tb.sv ***
// self-checking testbench of the boot stream loader
`include "bsl_map.svh"
module bsl_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk_i;
   logic reset_i = 1'b1;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic stream_valid_i;
   logic [7:0] stream_data_i;
   logic init_done_i = 1'b0;
   logic [3:0] delay = 4'h0;
   logic hreadyout_o, hresp_o, stream_req_o, mem_we_o, flash_16bit_o;
   logic supervisor_o, init_call_o, core_a_jump_o, core_b_run_o;
   logic sig_error_o;
   logic [31:0] hrdata_o, stream_addr_o, mem_addr_o, init_addr_o;
   logic [31:0] core_a_pc_o, core_b_pc_o;
   logic [7:0] mem_wdata_o;
   logic [3:0] wait_states_o, int_level_o;
   logic [1:0] hold_cycles_o;
   logic [2:0] spi_baud_o;
   int fails = 0, checks = 0, writes = 0, jumps = 0, reqs = 0;
   int inits = 0, init_reqs = 0, init_wait = 0, wp = 0;
   logic [7:0] seen [logic [31:0]];
   logic [31:0] init_addr_seen;
   localparam logic [31:0] exp_addr [7] = '{32'h1000_0000, 32'h1000_0001,
      32'h1000_0002, 32'h2000_0000, 32'h2000_0001, 32'h3000_0000,
      32'h4000_0000};
   localparam logic [7:0] exp_data [7] = '{8'h11, 8'h22, 8'h33, 8'h00,
      8'h00, 8'h44, 8'h55};

   bsl_loader dut (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o,
      .hresp_o, .hrdata_o, .stream_req_o, .stream_addr_o, .stream_valid_i,
      .stream_data_i, .mem_we_o, .mem_addr_o, .mem_wdata_o, .flash_16bit_o,
      .wait_states_o, .hold_cycles_o, .spi_baud_o, .int_level_o,
      .supervisor_o, .init_call_o, .init_addr_o, .init_done_i,
      .core_a_jump_o, .core_a_pc_o, .core_b_run_o, .core_b_pc_o,
      .sig_error_o);

   bsl_flash_model flash (.clk_i, .reset_i, .req_i(stream_req_o),
      .addr_i(stream_addr_o), .delay_i(delay), .valid_o(stream_valid_i),
      .data_o(stream_data_i));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // memory sink, init routine stand-in and event counters
   always @(posedge clk_i) begin
      if (mem_we_o === 1'b1) begin
         writes++;
         seen[mem_addr_o] = mem_wdata_o;
      end
      if (core_a_jump_o === 1'b1) jumps++;
      if (stream_req_o === 1'b1) reqs++;
      init_done_i <= (init_wait == 1);
      if (init_call_o === 1'b1) begin
         inits++;
         init_addr_seen = init_addr_o;
         init_wait = 6;
      end else if (init_wait > 0) begin
         if (stream_req_o === 1'b1) init_reqs++;
         init_wait--;
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task cmp(input string name, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= 2'b10;
      hwrite_i <= w;
      hsize_i <= 3'b010;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      r = hrdata_o;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask

   task rd_cmp(input string name, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      cmp(name, e, r);
      cmp("hresp", 32'h0, {31'h0, hresp_o});
   endtask

   task automatic wait_cnt(ref int c, input int n, input int lim);
      for (int i = 0; i < lim && c < n; i++) @(negedge clk_i);
   endtask

   task put(input logic [7:0] b);
      flash.mem[wp] = b;
      wp++;
   endtask

   task put32(input logic [31:0] v);
      for (int i = 0; i < 4; i++) put(v[8*i +: 8]);
   endtask

   task put_hdr(input logic [31:0] a, c, input logic [15:0] f);
      put32(a);
      put32(c);
      put(f[7:0]);
      put(f[15:8]);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task build_image;
      // unused bit 5 and reserved bit 20 set on purpose
      put32(32'ha010_02a7);
      put_hdr(32'hdead_beef, 32'h4, 16'h0010);
      put32(32'h0000_0040);
      put_hdr(32'h1000_0000, 32'h3, 16'h0000);
      put(8'h11);
      put(8'h22);
      put(8'h33);
      put_hdr(32'h2000_0000, 32'h2, 16'h0001);
      put_hdr(32'h3000_0000, 32'h1, 16'h0008);
      put(8'h44);
      put_hdr(32'h4000_0000, 32'h1, 16'h8000);
      put(8'h55);
   endtask

   task test_hard_boot;
      repeat (2) @(negedge clk_i);
      cmp("int_level", 32'hf, {28'h0, int_level_o});
      cmp("supervisor", 32'h1, {31'h0, supervisor_o});
      cmp("flash_16bit", 32'h0, {31'h0, flash_16bit_o});
      cmp("wait_states", 32'hf, {28'h0, wait_states_o});
      cmp("hold_cycles", 32'h3, {30'h0, hold_cycles_o});
      cmp("spi_baud", 32'h0, {29'h0, spi_baud_o});
      wait_cnt(jumps, 1, 3000);
      cmp("jumps", 32'h1, 32'(jumps));
      cmp("writes", 32'h7, 32'(writes));
      for (int i = 0; i < 7; i++)
         cmp("mem", exp_data[i], seen[exp_addr[i]]);
      cmp("inits", 32'h1, 32'(inits));
      cmp("init_addr", 32'h3000_0000, init_addr_seen);
      cmp("init_reqs", 32'h0, 32'(init_reqs));
      cmp("core_a_pc", `BSL_CORE_A_START, core_a_pc_o);
      cmp("flash_16bit", 32'h1, {31'h0, flash_16bit_o});
      cmp("wait_states", 32'h3, {28'h0, wait_states_o});
      cmp("hold_cycles", 32'h2, {30'h0, hold_cycles_o});
      cmp("spi_baud", 32'h2, {29'h0, spi_baud_o});
      // the collector now holds the final block header: flags, count top
      rd_cmp("ghdr", `BSL_OFF_GHDR, 32'h8000_0000);
      rd_cmp("unmapped", 8'h40, 32'h0);
   endtask

   task test_core_b;
      rd_cmp("core_a_cfg", `BSL_OFF_COREA, `BSL_COREA_RESET);
      cmp("core_b_run", 32'h0, {31'h0, core_b_run_o});
      // core A program clears the idle bit
      wr(`BSL_OFF_COREA, 32'h0);
      for (int i = 0; i < 8 && core_b_run_o !== 1'b1; i++) @(negedge clk_i);
      cmp("core_b_run", 32'h1, {31'h0, core_b_run_o});
      cmp("core_b_pc", `BSL_CORE_B_START, core_b_pc_o);
   endtask

   task test_soft_reset;
      int r0, w0;
      rd_cmp("sysrst", `BSL_OFF_SYSRST, `BSL_SYSRST_RESET);
      wr(`BSL_OFF_SYSRST, 32'h10);
      rd_cmp("sysrst", `BSL_OFF_SYSRST, 32'h10);
      delay <= 4'h3;
      r0 = reqs;
      w0 = writes;
      wr(`BSL_OFF_CTRL, 32'h1);
      wait_cnt(jumps, 2, 200);
      cmp("jumps", 32'h2, 32'(jumps));
      cmp("reqs", 32'(r0), 32'(reqs));
      cmp("writes", 32'(w0), 32'(writes));
      cmp("core_a_pc", `BSL_CORE_A_START, core_a_pc_o);
   endtask

   task test_bad_sig;
      int r0, w0, j0;
      wr(`BSL_OFF_SYSRST, 32'h0);
      flash.mem[3] = 8'h50;
      r0 = reqs;
      w0 = writes;
      j0 = jumps;
      wr(`BSL_OFF_CTRL, 32'h1);
      for (int i = 0; i < 300 && sig_error_o !== 1'b1; i++) @(negedge clk_i);
      cmp("sig_error", 32'h1, {31'h0, sig_error_o});
      cmp("reads", 32'h1, {31'h0, reqs > r0});
      // give a faulty loader time to go on copying
      repeat (200) @(negedge clk_i);
      cmp("writes", 32'(w0), 32'(writes));
      cmp("jumps", 32'(j0), 32'(jumps));
      cmp("wait_states", 32'h3, {28'h0, wait_states_o});
      rd_cmp("ghdr", `BSL_OFF_GHDR, 32'h5010_02a7);
      rd_cmp("status", `BSL_OFF_STATUS, 32'h0000_050c);
      rd_cmp("ptr", `BSL_OFF_PTR, 32'h4);
   endtask

   task report_and_stop;
      if (fails == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      build_image;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      test_hard_boot;
      test_core_b;
      test_soft_reset;
      test_bad_sig;
      report_and_stop;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop;
   end
endmodule
